// File: sim/adc_far_side.sv
// analog source, rc oscillator and compare unit facing the converter
// assumes the bench sets level and calls fire from its own thread
`timescale 1ns/10ps
module adc_far_side #(
  parameter int RC_HALF_NS = 100
) (
  input wire logic CLK,
  input wire logic [7:0] DAC_CODE,
  output logic COMPARATOR,
  output logic RC_CLK_PIN = 1'b0,
  output logic [3:0] COMPARE_UNIT_MODE = 4'h0,
  output logic COMPARE_TRIGGER = 1'b0
);
  logic [7:0] level = 8'h00;
  // ideal comparator: at or above the trial code reads high
  assign COMPARATOR = level >= DAC_CODE;
  // internal rc source runs free, unrelated in phase to CLK
  always #(RC_HALF_NS) RC_CLK_PIN = ~RC_CLK_PIN;
  // one-cycle compare trigger pulse in the given mode; caller selects channel first
  task automatic fire(input logic [3:0] mode);
    @(posedge CLK);
    COMPARE_UNIT_MODE <= mode;
    COMPARE_TRIGGER <= 1'b1;
    @(posedge CLK);
    COMPARE_TRIGGER <= 1'b0;
  endtask
endmodule

// File: sim/adc_sleep_reset_trigger_ctrl_sva.sv
// checker on the sequencer ports
// assumes one clock and the synchronous active-low reset
`timescale 1ns/10ps
module adc_ctrl_sva (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic CORE_SLEEP,
  input wire logic WAKE_REQ,
  input wire logic [3:0] COMPARE_UNIT_MODE,
  input wire logic COMPARE_TRIGGER,
  input wire logic TIMER_CLEAR,
  input wire logic [7:0] DAC_CODE,
  input wire logic CONV_POWER,
  input wire logic [7:0] ANALOG_INPUT_EN,
  input wire logic SAMPLE_EN
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence special_evt;
    COMPARE_TRIGGER && COMPARE_UNIT_MODE == 4'hb;
  endsequence
  a_event_clears_timer: assert property (special_evt |=> TIMER_CLEAR)
    else $error("timer clear missing");
  a_clear_has_cause: assert property (TIMER_CLEAR |-> $past(COMPARE_TRIGGER && COMPARE_UNIT_MODE == 4'hb))
    else $error("timer clear without event");
  a_reset_analog_pins: assert property (disable iff (1'b0) !RST_N |=> ANALOG_INPUT_EN == 8'hff)
    else $error("pins not analog after reset");
  a_reset_quiet: assert property (disable iff (1'b0) !RST_N |=> !CONV_POWER && !WAKE_REQ && DAC_CODE == 8'h00)
    else $error("converter active in reset");
  a_wake_from_sleep: assert property (WAKE_REQ |-> $past(CORE_SLEEP))
    else $error("wake without sleep");
  a_wake_single: assert property (WAKE_REQ |=> !WAKE_REQ)
    else $error("wake wider than one cycle");
  a_off_no_trial: assert property ($fell(CONV_POWER) |-> DAC_CODE == 8'h00)
    else $error("trial code while powered down");
  a_read_upper_zero: assert property (PSEL && !PENABLE |=> PRDATA[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_sample_no_trial: assert property (SAMPLE_EN |-> DAC_CODE == 8'h00)
    else $error("trial code during sampling");
endmodule
bind adc_sleep_reset_trigger_ctrl adc_ctrl_sva chk_i (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PRDATA(PRDATA), .CORE_SLEEP(CORE_SLEEP), .WAKE_REQ(WAKE_REQ), .COMPARE_UNIT_MODE(COMPARE_UNIT_MODE),
  .COMPARE_TRIGGER(COMPARE_TRIGGER), .TIMER_CLEAR(TIMER_CLEAR), .DAC_CODE(DAC_CODE), .CONV_POWER(CONV_POWER),
  .ANALOG_INPUT_EN(ANALOG_INPUT_EN), .SAMPLE_EN(SAMPLE_EN));

// File: sim/test_adc_sleep_reset_trigger_ctrl.sv
// bench: apb register tasks, conversions, sleep, trigger, reset
// assumes the far side model drives analog and compare inputs
`timescale 1ns/10ps
module test_adc_sleep_reset_trigger_ctrl;
  import adc_seq_pkg::*;
  logic CLK = 1'b0;
  logic RST_N, POR, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, CORE_SLEEP, WAKE_REQ, COMPARE_TRIGGER;
  logic TIMER_CLEAR, RC_CLK_PIN, COMPARATOR, SAMPLE_EN, CONV_POWER;
  logic [9:0] PADDR;
  logic [31:0] PWDATA, PRDATA, v;
  logic [3:0] COMPARE_UNIT_MODE;
  logic [7:0] DAC_CODE, ANALOG_INPUT_EN;
  logic [2:0] CHANNEL_SELECT, PORT_E_IN;
  logic [5:0] PORT_A_IN;
  logic [7:0] lv [3] = '{8'h00, 8'hff, 8'h5a};
  int error_cnt = 0;
  int checks = 0;
  int n;
  logic err;
  always #4 CLK = ~CLK;
  adc_sleep_reset_trigger_ctrl dut (.CLK(CLK), .RST_N(RST_N), .POR(POR), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CORE_SLEEP(CORE_SLEEP), .WAKE_REQ(WAKE_REQ), .COMPARE_UNIT_MODE(COMPARE_UNIT_MODE),
    .COMPARE_TRIGGER(COMPARE_TRIGGER), .TIMER_CLEAR(TIMER_CLEAR), .RC_CLK_PIN(RC_CLK_PIN),
    .COMPARATOR(COMPARATOR), .DAC_CODE(DAC_CODE), .SAMPLE_EN(SAMPLE_EN), .CONV_POWER(CONV_POWER),
    .CHANNEL_SELECT(CHANNEL_SELECT), .ANALOG_INPUT_EN(ANALOG_INPUT_EN), .PORT_A_IN(PORT_A_IN),
    .PORT_E_IN(PORT_E_IN));
  adc_far_side far (.CLK(CLK), .DAC_CODE(DAC_CODE), .COMPARATOR(COMPARATOR), .RC_CLK_PIN(RC_CLK_PIN),
    .COMPARE_UNIT_MODE(COMPARE_UNIT_MODE), .COMPARE_TRIGGER(COMPARE_TRIGGER));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] ctl(input logic [1:0] cs, input logic go);
    return {cs, 3'h1, go, 1'b0, 1'b1};
  endfunction
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic hang(input string what);
    error_cnt++;
    $display("mismatch %s expected done seen timeout", what);
    conclude();
  endtask
  // setup then access; request held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {idx, 2'b00};
    PWDATA <= {24'h000000, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) begin
      k++;
      if (k > 20) hang("pready");
      @(posedge CLK);
    end
    v = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    chk($sformatf("reg %h", idx), {24'h000000, e}, v);
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 300; k++) begin
      xfer(1'b0, IDX_CONV_CTRL, 8'h00);
      if (v[CTRL_GO_BIT] === 1'b0) break;
    end
    if (k == 300) hang("conversion");
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    {PSEL, PENABLE, PWRITE, CORE_SLEEP, RST_N, POR} = 6'h01;
    PADDR = 10'h000;
    PWDATA = 32'h00000000;
    PORT_A_IN = 6'h3f;
    PORT_E_IN = 3'h7;
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    POR <= 1'b0;
    rd(IDX_CONV_CTRL, 8'h00);
    rd(IDX_PIN_CONFIG, 8'h00);
    rd(IDX_PORT_A_DIR, 8'h3f);
    rd(IDX_PORT_E_DIR, 8'h07);
    rd(IDX_PERIPH_EN_1, 8'h00);
    rd(IDX_CONV_RESULT, RESULT_POR);
    rd(8'h40, 8'h00);
    chk("slverr", 32'h1, err);
    wr(IDX_CONV_CTRL, 8'hfb);
    rd(IDX_CONV_CTRL, 8'hf9);
    for (int i = 0; i < 3; i++) begin
      far.level = lv[i];
      wr(IDX_CONV_CTRL, ctl(i[1:0], 1'b0));
      repeat (2) @(negedge CLK);
      chk("channel", 32'h1, CHANNEL_SELECT);
      wr(IDX_CONV_CTRL, ctl(i[1:0], 1'b1));
      wait_idle();
      rd(IDX_CONV_RESULT, lv[i]);
      rd(IDX_PERIPH_FLAG_1, 8'h40);
      wr(IDX_PERIPH_FLAG_1, 8'h00);
    end
    wr(IDX_CONV_RESULT, 8'h33);
    wr(IDX_CONV_CTRL, ctl(CS_DIV32, 1'b1));
    wr(IDX_CONV_CTRL, ctl(CS_DIV32, 1'b0));
    repeat (10 * DIV32) @(posedge CLK);
    rd(IDX_CONV_RESULT, 8'h33);
    rd(IDX_PERIPH_FLAG_1, 8'h00);
    wr(IDX_CONV_CTRL, 8'h00);
    far.fire(MODE_SPECIAL_EVENT);
    rd(IDX_CONV_CTRL, 8'h00);
    wr(IDX_CONV_CTRL, ctl(CS_DIV32, 1'b0));
    far.level = 8'ha5;
    far.fire(4'ha);
    rd(IDX_CONV_CTRL, ctl(CS_DIV32, 1'b0));
    far.fire(MODE_SPECIAL_EVENT);
    rd(IDX_CONV_CTRL, ctl(CS_DIV32, 1'b1));
    far.fire(MODE_SPECIAL_EVENT);
    repeat (8 * DIV32) @(posedge CLK);
    rd(IDX_CONV_CTRL, ctl(CS_DIV32, 1'b1));
    wait_idle();
    rd(IDX_CONV_RESULT, 8'ha5);
    wr(IDX_PERIPH_FLAG_1, 8'h00);
    // sleep with a divided clock cuts the conversion short
    wr(IDX_CONV_CTRL, ctl(CS_DIV8, 1'b1));
    CORE_SLEEP <= 1'b1;
    repeat (4) @(negedge CLK);
    chk("power", 32'h0, CONV_POWER);
    rd(IDX_CONV_CTRL, ctl(CS_DIV8, 1'b0));
    rd(IDX_PERIPH_FLAG_1, 8'h00);
    CORE_SLEEP <= 1'b0;
    repeat (4) @(negedge CLK);
    chk("power", 32'h0, CONV_POWER);
    wr(IDX_CONV_CTRL, ctl(CS_DIV8, 1'b1));
    wait_idle();
    rd(IDX_PERIPH_FLAG_1, 8'h40);
    wr(IDX_PERIPH_FLAG_1, 8'h00);
    wr(IDX_PERIPH_EN_1, 8'h40);
    wr(IDX_GLOBAL_INT, 8'h40);
    rd(IDX_PERIPH_EN_1, 8'h40);
    far.level = 8'h81;
    wr(IDX_CONV_CTRL, ctl(CS_RC, 1'b0));
    wr(IDX_CONV_CTRL, ctl(CS_RC, 1'b1));
    CORE_SLEEP <= 1'b1;
    for (n = 0; n < 1000 && WAKE_REQ !== 1'b1; n++) @(negedge CLK);
    if (n == 1000) hang("wake");
    @(posedge CLK);
    CORE_SLEEP <= 1'b0;
    rd(IDX_CONV_CTRL, ctl(CS_RC, 1'b0));
    rd(IDX_CONV_RESULT, 8'h81);
    rd(IDX_PERIPH_FLAG_1, 8'h40);
    wr(IDX_PERIPH_FLAG_1, 8'h00);
    wr(IDX_PERIPH_EN_1, 8'h00);
    far.level = 8'h3c;
    wr(IDX_CONV_CTRL, ctl(CS_RC, 1'b1));
    CORE_SLEEP <= 1'b1;
    wait_idle();
    repeat (4) @(negedge CLK);
    chk("power", 32'h0, CONV_POWER);
    rd(IDX_CONV_CTRL, ctl(CS_RC, 1'b0));
    rd(IDX_CONV_RESULT, 8'h3c);
    CORE_SLEEP <= 1'b0;
    // warm reset mid conversion, then a power-on reset
    wr(IDX_PIN_CONFIG, 8'h07);
    repeat (2) @(negedge CLK);
    chk("analog pins", 32'h0, ANALOG_INPUT_EN);
    wr(IDX_CONV_CTRL, ctl(CS_DIV32, 1'b1));
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    rd(IDX_CONV_CTRL, 8'h00);
    rd(IDX_PIN_CONFIG, 8'h00);
    chk("analog pins", 32'hff, ANALOG_INPUT_EN);
    rd(IDX_CONV_RESULT, 8'h3c);
    RST_N <= 1'b0;
    POR <= 1'b1;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    POR <= 1'b0;
    rd(IDX_CONV_RESULT, RESULT_POR);
    conclude();
  end
endmodule

// File: verilog/adc_seq_pkg.sv
// constants, register map and state encoding of the converter sequencer
// assumes one 125 MHz clock (CLK) that also stands for the oscillator (Tosc = 8 ns)
package adc_seq_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PORT_A_PINS = 8'h05;
  localparam logic [7:0] IDX_PORT_E_PINS = 8'h09;
  localparam logic [7:0] IDX_GLOBAL_INT = 8'h0b;
  localparam logic [7:0] IDX_PERIPH_FLAG_1 = 8'h0c;
  localparam logic [7:0] IDX_PERIPH_FLAG_2 = 8'h0d;
  localparam logic [7:0] IDX_CONV_RESULT = 8'h1e;
  localparam logic [7:0] IDX_CONV_CTRL = 8'h1f;
  localparam logic [7:0] IDX_PORT_A_DIR = 8'h85;
  localparam logic [7:0] IDX_PORT_E_DIR = 8'h89;
  localparam logic [7:0] IDX_PERIPH_EN_1 = 8'h8c;
  localparam logic [7:0] IDX_PERIPH_EN_2 = 8'h8d;
  localparam logic [7:0] IDX_PIN_CONFIG = 8'h9f;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_GO_BIT = 2;
  localparam int CTRL_CH_LSB = 3;
  localparam int CTRL_CS_LSB = 6;
  localparam int DONE_FLAG_BIT = 6;
  localparam int INT_EN_BIT = 6;
  localparam int PERIPH_IE_BIT = 6;
  localparam int GLOBAL_IE_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] PIN_CFG_RESET = 3'h0;
  localparam logic [5:0] PORT_A_DIR_RESET = 6'h3f;
  localparam logic [2:0] PORT_E_DIR_RESET = 3'h7;
  localparam logic [7:0] RESULT_POR = 8'h00;

  // ----------------------------------------------------------------
  // clock select codes, compare mode, timing
  // ----------------------------------------------------------------
  localparam logic [1:0] CS_DIV2 = 2'h0;
  localparam logic [1:0] CS_DIV8 = 2'h1;
  localparam logic [1:0] CS_DIV32 = 2'h2;
  localparam logic [1:0] CS_RC = 2'h3;
  localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hb;
  localparam int DIV2 = 2;
  localparam int DIV8 = 8;
  localparam int DIV32 = 32;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int INSTR_CYCLE_PS = 32000;
  localparam int INSTR_CYCLES = (INSTR_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESULT_BITS = 8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_CONVERT = 2'b11
  } conv_state_t;

endpackage

// File: verilog/adc_sleep_reset_trigger_ctrl.sv
// converter sequencer: registers over apb, sleep handling, compare trigger
// assumes core sleep state, compare unit and comparator on CLK or synchronised here
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
module adc_sleep_reset_trigger_ctrl
  import adc_seq_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic POR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [9:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CORE_SLEEP,
  output logic WAKE_REQ,
  input wire logic [3:0] COMPARE_UNIT_MODE,
  input wire logic COMPARE_TRIGGER,
  output logic TIMER_CLEAR,
  input wire logic RC_CLK_PIN,
  input wire logic COMPARATOR,
  output logic [7:0] DAC_CODE,
  output logic SAMPLE_EN,
  output logic CONV_POWER,
  output logic [2:0] CHANNEL_SELECT,
  output logic [7:0] ANALOG_INPUT_EN,
  input wire logic [5:0] PORT_A_IN,
  input wire logic [2:0] PORT_E_IN
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  conv_state_t state;
  conv_state_t next_state;
  logic [1:0] conv_clock_select;
  logic [2:0] channel_select;
  logic go_flag;
  logic converter_on;
  logic [2:0] analog_pin_select;
  logic [7:0] conversion_result;
  logic conversion_done_flag;
  logic conversion_int_enable;
  logic peripheral_int_enable;
  logic global_int_enable;
  logic [5:0] port_a_direction;
  logic [2:0] port_e_direction;
  logic powered_down;
  logic sleep_prev;
  logic sleep_rise;
  logic [2:0] delay_count;
  logic [2:0] bit_index;
  logic [7:0] sar;
  logic [7:0] next_sar;
  logic tick;
  logic rc_level;
  logic comp_level;
  logic [5:0] port_a_sync;
  logic [2:0] port_e_sync;
  logic [7:0] analog_mask;
  logic [5:0] port_a_analog;
  logic [2:0] port_e_analog;
  logic [7:0] index;
  logic mapped;
  logic bus_write;
  logic ctrl_write;
  logic trigger_hit;
  logic trigger_start;
  logic write_start;
  logic write_abort;
  logic sleep_abort;
  logic abort;
  logic done;
  logic running;
  logic [7:0] read_value;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  level_sync #(.WIDTH(10)) pin_sync (
    .CLK(CLK),
    .RST_N(RST_N),
    .ASYNC_IN({RC_CLK_PIN, PORT_A_IN, PORT_E_IN}),
    .SYNC_OUT({rc_level, port_a_sync, port_e_sync})
  );

  // comparator follows DAC_CODE on this clock; two sync stages would outlast a 2-cycle bit
  assign comp_level = COMPARATOR;

  bit_period_tick period_gen (
    .CLK(CLK),
    .RST_N(RST_N),
    .RUN(running),
    .SELECT(conv_clock_select),
    .RC_LEVEL(rc_level),
    .TICK(tick)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign index = PADDR[9:2];
  assign bus_write = PSEL && PENABLE && PWRITE && mapped;
  assign ctrl_write = bus_write && (index == IDX_CONV_CTRL);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  always_comb begin
    mapped = (PADDR[1:0] == 2'h0);
    case (index)
      IDX_PORT_A_PINS, IDX_PORT_E_PINS, IDX_GLOBAL_INT: begin
      end
      IDX_PERIPH_FLAG_1, IDX_PERIPH_FLAG_2, IDX_CONV_RESULT: begin
      end
      IDX_CONV_CTRL, IDX_PORT_A_DIR, IDX_PORT_E_DIR: begin
      end
      IDX_PERIPH_EN_1, IDX_PERIPH_EN_2, IDX_PIN_CONFIG: begin
      end
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  assign sleep_rise = CORE_SLEEP && !sleep_prev;
  assign trigger_hit = COMPARE_TRIGGER && (COMPARE_UNIT_MODE == MODE_SPECIAL_EVENT);
  // trigger ignored while off or already converting
  assign trigger_start = trigger_hit && converter_on && !powered_down && !go_flag;
  assign write_start = ctrl_write && PWDATA[CTRL_GO_BIT] && PWDATA[CTRL_ON_BIT] && !go_flag;
  assign write_abort = ctrl_write && go_flag && !(PWDATA[CTRL_GO_BIT] && PWDATA[CTRL_ON_BIT]);
  assign sleep_abort = sleep_rise && (conv_clock_select != CS_RC);
  assign abort = write_abort || sleep_abort;
  assign running = (state == ST_SAMPLE) || (state == ST_CONVERT);
  assign done = (state == ST_CONVERT) && tick && (bit_index == 3'h0) && !abort;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sleep_prev <= 1'b0;
    end else begin
      sleep_prev <= CORE_SLEEP;
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (go_flag && !abort) begin
          // rc clock leaves room for the sleep instruction
          next_state = (conv_clock_select == CS_RC) ? ST_DELAY : ST_SAMPLE;
        end
      end
      ST_DELAY: begin
        if (delay_count == 3'(INSTR_CYCLES - 1)) begin
          next_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          next_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (done) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (abort || !go_flag) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N || state != ST_DELAY) begin
      delay_count <= 3'h0;
    end else begin
      delay_count <= delay_count + 3'h1;
    end
  end

  // one sample period then eight decisions, msb first
  always_comb begin
    next_sar = sar;
    if (!comp_level) begin
      next_sar[bit_index] = 1'b0;
    end
    if (bit_index != 3'h0) begin
      next_sar[bit_index - 3'h1] = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sar <= 8'h00;
      bit_index <= 3'h0;
    end else if (state == ST_SAMPLE && tick) begin
      sar <= 8'h80;
      bit_index <= 3'h7;
    end else if (state == ST_CONVERT && tick) begin
      sar <= next_sar;
      bit_index <= bit_index - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // control register and go flag
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      conv_clock_select <= CTRL_RESET[CTRL_CS_LSB +: 2];
      channel_select <= CTRL_RESET[CTRL_CH_LSB +: 3];
      converter_on <= CTRL_RESET[CTRL_ON_BIT];
    end else if (ctrl_write) begin
      conv_clock_select <= PWDATA[CTRL_CS_LSB +: 2];
      channel_select <= PWDATA[CTRL_CH_LSB +: 3];
      converter_on <= PWDATA[CTRL_ON_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      go_flag <= CTRL_RESET[CTRL_GO_BIT];
    end else if (done || abort) begin
      go_flag <= 1'b0;
    end else if (trigger_start || write_start) begin
      go_flag <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // power down across sleep
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      powered_down <= 1'b0;
    end else if (sleep_abort) begin
      powered_down <= 1'b1;
    end else if (done && CORE_SLEEP && !(conversion_int_enable && peripheral_int_enable)) begin
      powered_down <= 1'b1;
    end else if (ctrl_write && (!PWDATA[CTRL_ON_BIT] || (PWDATA[CTRL_GO_BIT] && !CORE_SLEEP))) begin
      powered_down <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // result, done flag, wake and timer clear
  // ----------------------------------------------------------------
  // not cleared by a plain reset: software may still read the last value
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      if (POR) begin
        conversion_result <= RESULT_POR;
      end
    end else if (done) begin
      conversion_result <= next_sar;
    end else if (bus_write && index == IDX_CONV_RESULT) begin
      conversion_result <= PWDATA[7:0];
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      conversion_done_flag <= 1'b0;
    end else if (done) begin
      conversion_done_flag <= 1'b1;
    end else if (bus_write && index == IDX_PERIPH_FLAG_1) begin
      conversion_done_flag <= PWDATA[DONE_FLAG_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      WAKE_REQ <= 1'b0;
      TIMER_CLEAR <= 1'b0;
    end else begin
      WAKE_REQ <= done && CORE_SLEEP && conversion_int_enable && peripheral_int_enable;
      TIMER_CLEAR <= trigger_hit;
    end
  end

  // ----------------------------------------------------------------
  // interrupt enables, directions, pin configuration
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      conversion_int_enable <= 1'b0;
      peripheral_int_enable <= 1'b0;
      global_int_enable <= 1'b0;
    end else if (bus_write && index == IDX_PERIPH_EN_1) begin
      conversion_int_enable <= PWDATA[INT_EN_BIT];
    end else if (bus_write && index == IDX_GLOBAL_INT) begin
      peripheral_int_enable <= PWDATA[PERIPH_IE_BIT];
      global_int_enable <= PWDATA[GLOBAL_IE_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      port_a_direction <= PORT_A_DIR_RESET;
      port_e_direction <= PORT_E_DIR_RESET;
      analog_pin_select <= PIN_CFG_RESET;
    end else if (bus_write && index == IDX_PORT_A_DIR) begin
      port_a_direction <= PWDATA[5:0];
    end else if (bus_write && index == IDX_PORT_E_DIR) begin
      port_e_direction <= PWDATA[2:0];
    end else if (bus_write && index == IDX_PIN_CONFIG) begin
      analog_pin_select <= PWDATA[2:0];
    end
  end

  // analog mask in channel order an0..an7 (ra0 ra1 ra2 ra3 ra5 re0 re1 re2)
  always_comb begin
    case (analog_pin_select)
      3'h0: analog_mask = 8'hff;
      3'h1: analog_mask = 8'hf7;
      3'h2: analog_mask = 8'h1f;
      3'h3: analog_mask = 8'h17;
      3'h4: analog_mask = 8'h0b;
      3'h5: analog_mask = 8'h03;
      default: analog_mask = 8'h00;
    endcase
  end

  // analog pins read back low
  assign port_a_analog = {analog_mask[4], 1'b0, analog_mask[3:0]};
  assign port_e_analog = analog_mask[7:5];

  // ----------------------------------------------------------------
  // read data, captured in the setup phase
  // ----------------------------------------------------------------
  always_comb begin
    case (index)
      IDX_PORT_A_PINS: read_value = {2'h0, port_a_sync & ~port_a_analog};
      IDX_PORT_E_PINS: read_value = {5'h00, port_e_sync & ~port_e_analog};
      IDX_GLOBAL_INT: read_value = {global_int_enable, peripheral_int_enable, 6'h00};
      IDX_PERIPH_FLAG_1: read_value = {1'b0, conversion_done_flag, 6'h00};
      IDX_CONV_RESULT: read_value = conversion_result;
      // converter_on reads back set while powered down
      IDX_CONV_CTRL: read_value = {conv_clock_select, channel_select, go_flag, 1'b0, converter_on};
      IDX_PORT_A_DIR: read_value = {2'h0, port_a_direction};
      IDX_PORT_E_DIR: read_value = {5'h00, port_e_direction};
      IDX_PERIPH_EN_1: read_value = {1'b0, conversion_int_enable, 6'h00};
      IDX_PIN_CONFIG: read_value = {5'h00, analog_pin_select};
      default: read_value = 8'h00;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE) begin
      PRDATA <= {24'h000000, mapped ? read_value : 8'h00};
    end
  end

  // ----------------------------------------------------------------
  // analog front end outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      DAC_CODE <= 8'h00;
      SAMPLE_EN <= 1'b0;
      CONV_POWER <= 1'b0;
      CHANNEL_SELECT <= 3'h0;
      ANALOG_INPUT_EN <= 8'hff;
    end else begin
      DAC_CODE <= (next_state == ST_CONVERT) ? ((state == ST_SAMPLE) ? 8'h80 : (tick ? next_sar : sar)) : 8'h00;
      SAMPLE_EN <= (next_state == ST_SAMPLE) || (next_state == ST_DELAY);
      CONV_POWER <= converter_on && !powered_down;
      CHANNEL_SELECT <= channel_select;
      ANALOG_INPUT_EN <= analog_mask;
    end
  end

endmodule

// File: verilog/bit_period_tick.sv
// one-cycle enable at every conversion bit period boundary
// assumes RC_LEVEL already synchronised; counter restarts while RUN is low
`timescale 1ns/10ps
module bit_period_tick
  import adc_seq_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic RUN,
  input wire logic [1:0] SELECT,
  input wire logic RC_LEVEL,
  output logic TICK
);

  logic [4:0] count;
  logic [4:0] last;
  logic rc_prev;

  always_comb begin
    case (SELECT)
      CS_DIV2: last = 5'(DIV2 - 1);
      CS_DIV8: last = 5'(DIV8 - 1);
      default: last = 5'(DIV32 - 1);
    endcase
  end

  // restart keeps the first bit period whole
  always_ff @(posedge CLK) begin
    if (!RST_N || !RUN) begin
      count <= 5'h00;
    end else if (count == last) begin
      count <= 5'h00;
    end else begin
      count <= count + 5'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rc_prev <= 1'b0;
    end else begin
      rc_prev <= RC_LEVEL;
    end
  end

  // rc period counted on rising edges of the rc oscillator
  always_comb begin
    if (SELECT == CS_RC) begin
      TICK = RUN && RC_LEVEL && !rc_prev;
    end else begin
      TICK = RUN && (count == last);
    end
  end

endmodule

// File: verilog/level_sync.sv
// two flip-flop synchroniser for a bus of independent levels
// assumes each bit changes slowly against CLK; bits are not coherent
`timescale 1ns/10ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [WIDTH-1:0] ASYNC_IN,
  output logic [WIDTH-1:0] SYNC_OUT
);

  logic [WIDTH-1:0] stage_one;

  initial begin
    if (WIDTH < 1) $error("level_sync width must be positive");
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      stage_one <= '0;
      SYNC_OUT <= '0;
    end else begin
      stage_one <= ASYNC_IN;
      SYNC_OUT <= stage_one;
    end
  end

endmodule
